// ==== fdr_bank.sv ====
// Serial target interface and configuration register bank of the flash driver.
`timescale 1ns/1ps
//
// Function
// RL1 - Answer only target address 1100011
// RL2 - Eighth address bit: 0 write, 1 read
// RL3 - Second write byte selects register index
// RL4 - Third write byte stored into selected register
// RL5 - Thirteen registers at indices 0x01 to 0x0D
// RL6 - Reset loads table values into registers
// RL7 - Enable bits for sync, strobe, torch pin
// RL8 - Mode field and two channel enables
// RL9 - Strobe type bit: level or edge
// RL10 - Controller avoids edge strobe with infrared
// RL11 - Strobe pulses held longer than 1ms
// RL12 - Monitor lockout, hysteresis, mode, reserved bit
// RL13 - Monitor threshold code 2.9V to 3.6V
// RL14 - Monitor mode frozen while device active
// RL15 - Follow bit copies first channel flash code
// RL16 - Flash code sets linear channel current
// RL17 - Second flash register: code, reserved top
// RL18 - Acknowledge received bytes, never returned bytes
// RL19 - Read: index write, restart, clock out
// RL20 - Reserved bits and unmapped indices read zero
module fdr_bank
    import fdr_pkg::*;
#(
    // Arbitrary identity value.
    parameter logic [7:0] PART_ID = 8'hA5
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    input wire fdr_status_s status,
    output fdr_cfg_s cfg
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_INDEX,
        ST_WDATA,
        ST_ACK,
        ST_READ,
        ST_MACK
    } fdr_state_e;

    logic scl_lvl, scl_rise, scl_fall;
    logic sda_lvl, sda_rise, sda_fall;
    logic start_evt, stop_evt;

    fdr_pin_sync u_scl (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .pin(scl_i),
        .level(scl_lvl),
        .rise(scl_rise),
        .fall(scl_fall)
    );

    fdr_pin_sync u_sda (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .pin(sda_i),
        .level(sda_lvl),
        .rise(sda_rise),
        .fall(sda_fall)
    );

    assign start_evt = sda_fall & scl_lvl;
    assign stop_evt = sda_rise & scl_lvl;

    ////////////////////////////////////////////////////////////////////////////////
    // Register storage and read decode.

    logic [7:0] regs_q [1:9];
    logic [7:0] regs_d [1:9];
    logic wr_fire;
    logic [7:0] wr_idx, wr_data;

    function automatic logic mapped_rw(input logic [7:0] idx);
        return (idx >= FDR_IDX_MAIN_ENABLE) && (idx <= FDR_IDX_THERMISTOR_CFG);
    endfunction

    function automatic logic [7:0] read_value(input logic [7:0] idx);
        logic [7:0] v;
        v = 8'h00;
        if (mapped_rw(idx)) begin
            v = regs_q[idx[3:0]];
        end else if (idx == FDR_IDX_FAULT_FLAGS_FIRST) begin
            v = status.fault_flags_first;
        end else if (idx == FDR_IDX_FAULT_FLAGS_SECOND) begin
            v = status.fault_flags_second;
        end else if (idx == FDR_IDX_PART_IDENTITY) begin
            v = PART_ID;
        end else if (idx == FDR_IDX_PREVIOUS_FLASH) begin
            v = status.previous_flash_record;
        end
        return v; // RL5 RL20
    endfunction

    fdr_mode_e cur_mode;
    assign cur_mode = fdr_mode_e'(regs_q[1][FDR_EN_MODE_HI:FDR_EN_MODE_LO]);

    always_comb begin
        logic [7:0] mask;
        mask = 8'h00;
        for (int i = 1; i <= FDR_NUM_RW; i++) begin
            regs_d[i] = regs_q[i];
        end
        if (wr_fire && mapped_rw(wr_idx)) begin
            mask = FDR_WMASK[wr_idx[3:0]]; // RL20
            // Changing the monitor mode mid-flash would upset the supply loop.
            if (wr_idx == FDR_IDX_MONITOR_CFG && cur_mode != FDR_MODE_STANDBY) begin
                mask = mask & ~FDR_MON_MODE_MASK; // RL14
            end
            regs_d[wr_idx[3:0]] = (regs_q[wr_idx[3:0]] & ~mask) | (wr_data & mask); // RL4
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 1; i <= FDR_NUM_RW; i++) begin
                regs_q[i] <= FDR_RESET_VALUES[i]; // RL6
            end
        end else begin
            for (int i = 1; i <= FDR_NUM_RW; i++) begin
                regs_q[i] <= regs_d[i];
            end
        end
    end

    // Configuration fields handed to the analog and timing logic.
    always_comb begin
        cfg.tx_sync_en = regs_q[1][FDR_EN_TX_SYNC]; // RL7
        cfg.strobe_edge = regs_q[1][FDR_EN_STROBE_TYPE]; // RL9
        cfg.strobe_en = regs_q[1][FDR_EN_STROBE]; // RL7
        cfg.torch_pin_en = regs_q[1][FDR_EN_TORCH_PIN]; // RL7
        cfg.operating_mode = cur_mode; // RL8
        cfg.second_output_channel_on = regs_q[1][FDR_EN_SECOND_CH]; // RL8
        cfg.first_output_channel_on = regs_q[1][FDR_EN_FIRST_CH]; // RL8
        cfg.undervoltage_lockout_en = regs_q[2][FDR_MON_UNDERVOLTAGE_LOCKOUT]; // RL12
        cfg.monitor_level = regs_q[2][FDR_MON_LEVEL_HI:FDR_MON_LEVEL_LO]; // RL13
        cfg.monitor_hyst_50mv = regs_q[2][FDR_MON_HYST]; // RL12
        cfg.monitor_mode = regs_q[2][1:0]; // RL12
        cfg.first_flash_code = regs_q[3][6:0]; // RL16
        if (regs_q[3][FDR_FLASH_FOLLOW]) begin
            cfg.second_flash_code = regs_q[3][6:0]; // RL15
        end else begin
            cfg.second_flash_code = regs_q[4][6:0]; // RL17
        end
        cfg.primary_torch_level = regs_q[5];
        cfg.secondary_torch_level = regs_q[6];
        cfg.converter_config = regs_q[7];
        cfg.timing_config = regs_q[8];
        cfg.thermistor_config = regs_q[9];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Byte engine of the serial target.

    fdr_state_e state_q, state_d, after_q, after_d;
    logic [3:0] bit_cnt_q, bit_cnt_d;
    logic [7:0] shift_q, shift_d, index_q, index_d;
    logic drive_q, drive_d;

    always_comb begin
        state_d = state_q;
        after_d = after_q;
        bit_cnt_d = bit_cnt_q;
        shift_d = shift_q;
        index_d = index_q;
        drive_d = drive_q;
        wr_fire = 1'b0;
        wr_idx = index_q;
        wr_data = shift_q;
        if (start_evt) begin
            state_d = ST_ADDR; // RL19
            bit_cnt_d = 4'h0;
            drive_d = 1'b0;
        end else if (stop_evt) begin
            state_d = ST_IDLE;
            drive_d = 1'b0;
        end else begin
            case (state_q)
                ST_ADDR, ST_INDEX, ST_WDATA: begin
                    if (scl_rise && bit_cnt_q < 4'h8) begin
                        shift_d = {shift_q[6:0], sda_lvl};
                        bit_cnt_d = bit_cnt_q + 4'h1;
                    end else if (scl_fall && bit_cnt_q == 4'h8) begin
                        bit_cnt_d = 4'h0;
                        state_d = ST_ACK;
                        drive_d = 1'b1; // RL18
                        if (state_q == ST_ADDR) begin
                            if (shift_q[7:1] != FDR_TARGET_ADDR) begin
                                state_d = ST_IDLE; // RL1
                                drive_d = 1'b0;
                            end else if (shift_q[0] == FDR_DIR_READ) begin
                                after_d = ST_READ; // RL2
                            end else begin
                                after_d = ST_INDEX; // RL2
                            end
                        end else if (state_q == ST_INDEX) begin
                            index_d = shift_q; // RL3
                            after_d = ST_WDATA;
                        end else begin
                            wr_fire = 1'b1; // RL4
                            index_d = index_q + 8'h01;
                            after_d = ST_WDATA;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        state_d = after_q;
                        drive_d = 1'b0;
                        if (after_q == ST_READ) begin
                            shift_d = read_value(index_q); // RL19
                            drive_d = ~shift_d[7];
                        end
                    end
                end
                ST_READ: begin
                    if (scl_rise) begin
                        bit_cnt_d = bit_cnt_q + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt_q == 4'h8) begin
                            state_d = ST_MACK;
                            drive_d = 1'b0; // RL18
                        end else begin
                            shift_d = {shift_q[6:0], 1'b0};
                            drive_d = ~shift_d[7];
                        end
                    end
                end
                ST_MACK: begin
                    // The controller acknowledges; a high bit ends the read.
                    if (scl_rise) begin
                        bit_cnt_d = 4'h0;
                        if (sda_lvl) begin
                            state_d = ST_IDLE;
                        end else begin
                            state_d = ST_ACK;
                            after_d = ST_READ;
                            index_d = index_q + 8'h01;
                        end
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
            after_q <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            index_q <= 8'h00;
            drive_q <= 1'b0;
        end else begin
            state_q <= state_d;
            after_q <= after_d;
            bit_cnt_q <= bit_cnt_d;
            shift_q <= shift_d;
            index_q <= index_d;
            drive_q <= drive_d;
        end
    end

    // Open-drain data line: only ever pulled low.
    assign sda_o = 1'b0;
    assign sda_oe_n = ~drive_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    chk_addr_mismatch: assert property (@(posedge sys_clk) disable iff (!resetn) // RL1
        (state_q == ST_ADDR && !start_evt && !stop_evt && scl_fall && bit_cnt_q == 4'h8
            && shift_q[7:1] != FDR_TARGET_ADDR) |=> (state_q == ST_IDLE && !drive_q))
        else $error("Foreign address was not ignored.");

    chk_addr_ack: assert property (@(posedge sys_clk) disable iff (!resetn) // RL18
        (state_q == ST_ADDR && !start_evt && !stop_evt && scl_fall && bit_cnt_q == 4'h8
            && shift_q[7:1] == FDR_TARGET_ADDR) |=> drive_q && state_q == ST_ACK)
        else $error("Own address was not acknowledged.");

    chk_dir_select: assert property (@(posedge sys_clk) disable iff (!resetn) // RL2
        (state_q == ST_ADDR && !start_evt && !stop_evt && scl_fall && bit_cnt_q == 4'h8
            && shift_q[7:1] == FDR_TARGET_ADDR)
            |=> (after_q == ST_READ) == $past(shift_q[0]))
        else $error("Direction bit chose the wrong path.");

    chk_index_load: assert property (@(posedge sys_clk) disable iff (!resetn) // RL3
        (state_q == ST_INDEX && !start_evt && !stop_evt && scl_fall && bit_cnt_q == 4'h8)
            |=> index_q == $past(shift_q) && after_q == ST_WDATA)
        else $error("Index byte was not taken.");

    chk_write_store: assert property (@(posedge sys_clk) disable iff (!resetn) // RL4
        (wr_fire && wr_idx == FDR_IDX_MAIN_ENABLE) |=> regs_q[1] == $past(wr_data))
        else $error("Write data was not stored.");

    chk_reset_values: assert property (@(posedge sys_clk) disable iff (!resetn) // RL6
        $rose(resetn) |-> regs_q[1] == 8'h80 && regs_q[3] == 8'hBF && regs_q[4] == 8'h3F)
        else $error("Register reset value is wrong.");

    chk_mode_frozen: assert property (@(posedge sys_clk) disable iff (!resetn) // RL14
        (wr_fire && wr_idx == FDR_IDX_MONITOR_CFG && cur_mode != FDR_MODE_STANDBY)
            |=> regs_q[2][1:0] == $past(regs_q[2][1:0]))
        else $error("Monitor mode changed while active.");

    chk_no_read_ack: assert property (@(posedge sys_clk) disable iff (!resetn) // RL18
        (state_q == ST_READ && scl_fall && bit_cnt_q == 4'h8 && !start_evt && !stop_evt)
            |=> !drive_q [*2])
        else $error("Returned byte was acknowledged.");

    chk_unmapped_zero: assert property (@(posedge sys_clk) disable iff (!resetn) // RL20
        (state_q == ST_ACK && after_q == ST_READ && scl_fall && !start_evt && !stop_evt
            && (index_q == 8'h00 || index_q > FDR_IDX_PREVIOUS_FLASH))
            |=> shift_q == 8'h00 && drive_q)
        else $error("Unmapped index did not read zero.");

    chk_follow_code: assert property (@(posedge sys_clk) disable iff (!resetn) // RL15
        (wr_fire && wr_idx == FDR_IDX_PRIMARY_FLASH && wr_data[7])
            |=> cfg.second_flash_code == $past(wr_data[6:0]))
        else $error("Second channel did not follow the first.");

endmodule

// ==== fdr_host_model.sv ====
// Bus controller model that clocks the serial link and pulls the data line.
`timescale 1ns/1ps
module fdr_host_model (
    input wire logic sys_clk,
    input wire logic sda_wire,
    output logic scl,
    output logic sda_oe_n,
    output logic [7:0] rd_byte,
    output logic rd_valid
);
    initial begin
        scl = 1'b1;
        sda_oe_n = 1'b1;
        rd_byte = 8'h00;
        rd_valid = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // Each phase lasts eight cycles so that the three-flop synchronisers settle on it.
    task automatic bit_io(input logic b, output logic r);
        tick(4);
        sda_oe_n <= b;
        tick(4);
        scl <= 1'b1;
        tick(7);
        r = sda_wire;
        tick(1);
        scl <= 1'b0;
    endtask

    // Data is released and the clock raised unconditionally. The clock may have been lowered in
    // this very time step, so testing its value here would still see it high.
    task automatic start();
        tick(4);
        sda_oe_n <= 1'b1;
        tick(4);
        scl <= 1'b1;
        tick(8);
        sda_oe_n <= 1'b0;
        tick(8);
        scl <= 1'b0;
    endtask

    task automatic stop();
        tick(4);
        sda_oe_n <= 1'b0;
        tick(4);
        scl <= 1'b1;
        tick(8);
        sda_oe_n <= 1'b1;
        tick(8);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Address with direction bit, then index, then data, all most significant bit first.
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, ack);
    endtask

    // The last byte of a read is refused by the controller to end the transfer.
    task automatic recv(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(last, r);
        rd_byte <= d;
        rd_valid <= 1'b1;
        tick(1);
        rd_valid <= 1'b0;
    endtask
endmodule

// ==== fdr_pin_sync.sv ====
// Three-stage synchroniser for one bus line with a settled level and edge pulses.
`timescale 1ns/1ps
module fdr_pin_sync
    import fdr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic pin,
    output logic level,
    output logic rise,
    output logic fall
);

    logic s1_q, s2_q, s3_q, lvl_q, lvl_d;

    always_comb begin
        lvl_d = lvl_q;
        if (s2_q == s3_q) begin
            lvl_d = s3_q;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s1_q <= FDR_LINE_IDLE;
            s2_q <= FDR_LINE_IDLE;
            s3_q <= FDR_LINE_IDLE;
            lvl_q <= FDR_LINE_IDLE;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    // Edges are flagged in the cycle before the settled level output changes.
    assign level = lvl_q;
    assign rise = lvl_d & ~lvl_q;
    assign fall = ~lvl_d & lvl_q;

endmodule

// ==== fdr_pkg.sv ====
// Package holding the register map, field layouts and carrier types of the flash driver bank.
package fdr_pkg;

    // Target address and direction encoding.
    localparam logic [6:0] FDR_TARGET_ADDR = 7'h63;
    localparam logic FDR_DIR_WRITE = 1'b0;
    localparam logic FDR_DIR_READ = 1'b1;

    // Internal register indices.
    localparam logic [7:0] FDR_IDX_MAIN_ENABLE = 8'h01;
    localparam logic [7:0] FDR_IDX_MONITOR_CFG = 8'h02;
    localparam logic [7:0] FDR_IDX_PRIMARY_FLASH = 8'h03;
    localparam logic [7:0] FDR_IDX_SECONDARY_FLASH = 8'h04;
    localparam logic [7:0] FDR_IDX_PRIMARY_TORCH = 8'h05;
    localparam logic [7:0] FDR_IDX_SECONDARY_TORCH = 8'h06;
    localparam logic [7:0] FDR_IDX_CONVERTER_CFG = 8'h07;
    localparam logic [7:0] FDR_IDX_TIMING_CFG = 8'h08;
    localparam logic [7:0] FDR_IDX_THERMISTOR_CFG = 8'h09;
    localparam logic [7:0] FDR_IDX_FAULT_FLAGS_FIRST = 8'h0A;
    localparam logic [7:0] FDR_IDX_FAULT_FLAGS_SECOND = 8'h0B;
    localparam logic [7:0] FDR_IDX_PART_IDENTITY = 8'h0C;
    localparam logic [7:0] FDR_IDX_PREVIOUS_FLASH = 8'h0D;
    localparam int FDR_NUM_RW = 9;

    // Values after reset of the writable registers, indices 1 to 9.
    localparam logic [7:0] FDR_RESET_VALUES [1:9] = '{
        8'h80, 8'h01, 8'hBF, 8'h3F, 8'hBF, 8'h3F, 8'h09, 8'h1A, 8'h08
    };

    // Writable bits; reserved bits are zero here and read back as zero.
    localparam logic [7:0] FDR_WMASK [1:9] = '{
        8'hFF, 8'h7F, 8'hFF, 8'h7F, 8'hFF, 8'h7F, 8'h8F, 8'h7F, 8'h7F
    };

    // Field positions of the main enable register.
    localparam int FDR_EN_TX_SYNC = 7;
    localparam int FDR_EN_STROBE_TYPE = 6;
    localparam int FDR_EN_STROBE = 5;
    localparam int FDR_EN_TORCH_PIN = 4;
    localparam int FDR_EN_MODE_HI = 3;
    localparam int FDR_EN_MODE_LO = 2;
    localparam int FDR_EN_SECOND_CH = 1;
    localparam int FDR_EN_FIRST_CH = 0;

    // Field positions of the input voltage monitor register.
    localparam int FDR_MON_UNDERVOLTAGE_LOCKOUT = 6;
    localparam int FDR_MON_LEVEL_HI = 5;
    localparam int FDR_MON_LEVEL_LO = 3;
    localparam int FDR_MON_HYST = 2;
    localparam logic [7:0] FDR_MON_MODE_MASK = 8'h03;

    // Position of the follow bit in the primary flash register.
    localparam int FDR_FLASH_FOLLOW = 7;

    // Values after reset of synchronised bus lines, which idle high.
    localparam logic FDR_LINE_IDLE = 1'b1;

    typedef enum logic [1:0] {
        FDR_MODE_STANDBY,
        FDR_MODE_INFRARED,
        FDR_MODE_TORCH,
        FDR_MODE_FLASH
    } fdr_mode_e;

    typedef struct packed {
        logic tx_sync_en;
        logic strobe_edge;
        logic strobe_en;
        logic torch_pin_en;
        fdr_mode_e operating_mode;
        logic second_output_channel_on;
        logic first_output_channel_on;
        logic undervoltage_lockout_en;
        logic [2:0] monitor_level;
        logic monitor_hyst_50mv;
        logic [1:0] monitor_mode;
        logic [6:0] first_flash_code;
        logic [6:0] second_flash_code;
        logic [7:0] primary_torch_level;
        logic [7:0] secondary_torch_level;
        logic [7:0] converter_config;
        logic [7:0] timing_config;
        logic [7:0] thermistor_config;
    } fdr_cfg_s;

    typedef struct packed {
        logic [7:0] fault_flags_first;
        logic [7:0] fault_flags_second;
        logic [7:0] previous_flash_record;
    } fdr_status_s;

endpackage

// ==== flash_driver_i2c_register_bank_tb.sv ====
// Self-checking testbench of the flash driver register bank.
`timescale 1ns/1ps
module flash_driver_i2c_register_bank_tb;
    import fdr_pkg::*;
    // Arbitrary identity value.
    localparam logic [7:0] ID = 8'h5C;
    logic sys_clk;
    logic resetn;
    logic scl;
    logic host_oe_n;
    logic sda_o;
    logic sda_oe_n;
    logic sda_wire;
    logic [7:0] rd_byte;
    logic rd_valid;
    fdr_status_s status;
    fdr_cfg_s cfg;
    logic [7:0] exp_q [$];
    logic [7:0] wq [$];
    logic [7:0] mdl [0:15];
    int fail_count = 0;
    int tests_run = 0;
    int seed = 32'h62b6;

    // Open-drain line with a pull-up: low when either party pulls.
    assign sda_wire = (sda_oe_n ? 1'b1 : sda_o) & host_oe_n;

    fdr_bank #(.PART_ID(ID)) dut (.sys_clk(sys_clk), .resetn(resetn), .scl_i(scl),
        .sda_i(sda_wire), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .status(status), .cfg(cfg));
    fdr_host_model host (.sys_clk(sys_clk), .sda_wire(sda_wire), .scl(scl),
        .sda_oe_n(host_oe_n), .rd_byte(rd_byte), .rd_valid(rd_valid));

    always #25 sys_clk = ~sys_clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("Counts: %0d compares, %0d mismatches", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_test(input string name);
        $display("Test %s finished at %0t", name, $time);
    endtask

    task automatic mdl_reset();
        logic [7:0] rv [1:9];
        rv = '{8'h80, 8'h01, 8'hBF, 8'h3F, 8'hBF, 8'h3F, 8'h09, 8'h1A, 8'h08};
        for (int k = 1; k <= 9; k++) begin
            mdl[k] = rv[k];
        end
    endtask

    task automatic set_status();
        logic [31:0] st;
        st = $random(seed);
        status <= fdr_status_s'(st[23:0]);
        mdl[10] = st[23:16];
        mdl[11] = st[15:8];
        mdl[13] = st[7:0];
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Writes the bytes of wq from index idx on and tracks what the bank must hold.
    task automatic wr(input logic [6:0] addr, input logic [7:0] idx, input logic exp_ack);
        logic a;
        logic [7:0] v;
        int k;
        k = idx;
        host.start();
        host.send({addr, FDR_DIR_WRITE}, a);
        chk(72'(a), 72'(!exp_ack));
        if (exp_ack) begin
            host.send(idx, a);
            chk(72'(a), 72'h0);
            foreach (wq[i]) begin
                host.send(wq[i], a);
                chk(72'(a), 72'h0);
                if (k >= 1 && k <= 9) begin
                    v = wq[i] & FDR_WMASK[k];
                    if (k == 2 && mdl[1][3:2] != 2'b00) begin
                        v[1:0] = mdl[2][1:0];
                    end
                    mdl[k] = v;
                end
                k++;
            end
        end
        host.stop();
    endtask

    task automatic rd(input logic [7:0] idx, input int n);
        logic a;
        logic [7:0] d;
        for (int i = 0; i < n; i++) begin
            exp_q.push_back(mdl[idx + i]);
        end
        host.start();
        host.send({FDR_TARGET_ADDR, FDR_DIR_WRITE}, a);
        host.send(idx, a);
        host.start();
        host.send({FDR_TARGET_ADDR, FDR_DIR_READ}, a);
        chk(72'(a), 72'h0);
        for (int i = 0; i < n; i++) begin
            host.recv(i == n - 1, d);
        end
        host.stop();
    endtask

    task automatic chk_cfg();
        logic [7:0] s;
        logic [68:0] e;
        s = mdl[3][7] ? mdl[3] : mdl[4];
        e = {mdl[1], mdl[2][6:0], mdl[3][6:0], s[6:0], mdl[5], mdl[6], mdl[7], mdl[8], mdl[9]};
        chk(72'(cfg), 72'(e));
    endtask

    // Every returned byte is paired with the oldest expected value.
    always @(posedge sys_clk) begin
        if (rd_valid === 1'b1) begin
            chk(72'(rd_byte), exp_q.size() > 0 ? 72'(exp_q.pop_front()) : {72{1'bx}});
        end
    end

    initial begin
        repeat (90000) @(posedge sys_clk);
        fail_count++;
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        resetn = 1'b0;
        status = '0;
        mdl[0] = 8'h00;
        mdl[12] = ID;
        mdl[14] = 8'h00;
        mdl[15] = 8'h00;
        mdl_reset();
        set_status();
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (6) @(posedge sys_clk);
        chk_cfg();
        rd(8'h00, 15);
        end_test("reset values");
        for (int n = 0; n < 3; n++) begin
            // Standby keeps the monitor mode writable; edge strobe never meets infrared.
            wq = {8'($random(seed)) & 8'hF3};
            wr(FDR_TARGET_ADDR, FDR_IDX_MAIN_ENABLE, 1'b1);
            wq = {};
            for (int k = 2; k <= 9; k++) begin
                wq.push_back(8'($random(seed)));
            end
            wq[1][7] = n[0];
            wr(FDR_TARGET_ADDR, FDR_IDX_MONITOR_CFG, 1'b1);
            chk_cfg();
            rd(8'h01, 9);
        end
        end_test("random writes");
        for (int m = 0; m < 4; m++) begin
            wq = {8'h80 | 8'(m << 2)};
            wr(FDR_TARGET_ADDR, FDR_IDX_MAIN_ENABLE, 1'b1);
            wq = {8'($random(seed))};
            wr(FDR_TARGET_ADDR, FDR_IDX_MONITOR_CFG, 1'b1);
            chk_cfg();
        end
        end_test("modes and monitor freeze");
        for (int b = 0; b < 7; b++) begin
            wq = {~mdl[5]};
            wr(FDR_TARGET_ADDR ^ 7'(1 << b), FDR_IDX_PRIMARY_TORCH, 1'b0);
        end
        rd(FDR_IDX_PRIMARY_TORCH, 1);
        end_test("foreign addresses");
        wq = {8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
        wr(FDR_TARGET_ADDR, FDR_IDX_FAULT_FLAGS_FIRST, 1'b1);
        wq = {8'hFF};
        wr(FDR_TARGET_ADDR, 8'h00, 1'b1);
        set_status();
        repeat (2) @(posedge sys_clk);
        rd(FDR_IDX_FAULT_FLAGS_FIRST, 5);
        end_test("read-only and unmapped");
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        mdl_reset();
        repeat (6) @(posedge sys_clk);
        chk_cfg();
        rd(8'h00, 15);
        end_test("second reset");
        repeat (4) @(posedge sys_clk);
        give_verdict();
    end
endmodule
